//--- rxad_cfg.svh
// Register map, field positions, reset values and command codes of the rx mode / antenna driver block
`ifndef RXAD_CFG_SVH
`define RXAD_CFG_SVH
// Byte addresses on the register bus
`define RXAD_ADDR_CMD       8'h04
`define RXAD_ADDR_RX_MODE   8'h10
`define RXAD_ADDR_DRV_CTL   8'h14
`define RXAD_ADDR_RX_AUX    8'h18
`define RXAD_ADDR_STATUS    8'h1c
// Reset values
`define RXAD_DRV_CTL_RST    8'h80
`define RXAD_RX_MODE_RST    8'h00
`define RXAD_RX_AUX_RST     8'h00
// Receive mode fields
`define RXAD_RM_CRC         7
`define RXAD_RM_RATE_HI     6
`define RXAD_RM_RATE_LO     4
`define RXAD_RM_IGNORE      3
`define RXAD_RM_MULTI       2
`define RXAD_RM_FMT_HI      1
// Driver control fields (inversion bits sit at base plus driver index)
`define RXAD_DC_INV_ON      6
`define RXAD_DC_INV_OFF     4
`define RXAD_DC_CW          3
`define RXAD_DC_GUARD       2
// Rate codes and short frame limit
`define RXAD_RATE_424       3'h2
`define RXAD_RATE_3392      3'h5
`define RXAD_SHORT_BITS     8'h04
// Command codes
`define RXAD_CMD_RECEIVE    4'h8
`define RXAD_CMD_TRANSCEIVE 4'hc
`endif

//--- rxad_pkg.sv
// Types shared by the rx mode / antenna driver block
package rxad_pkg;
  // Expected framing of received data
  typedef enum logic [1:0] {
    RXAD_FMT_A_106   = 2'h0,
    RXAD_FMT_ACTIVE  = 2'h1,
    RXAD_FMT_PASSIVE = 2'h2,
    RXAD_FMT_B       = 2'h3
  } rxad_fmt_t;
  // Receiver activity
  typedef enum logic {RXAD_RX_IDLE, RXAD_RX_LISTEN} rxad_rx_state_t;
endpackage

//--- rxad_rf_model.sv
// Model of the RF front end: carrier sample, received bit stream and error byte
module rxad_rf_model (
  input  wire logic       aclk,
  output logic            carrier_in,
  output logic            rx_bit_valid,
  output logic            rx_frame_end,
  output logic [7:0]      error_reg_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    carrier_in = 1'b0;
    rx_bit_valid = 1'b0;
    rx_frame_end = 1'b0;
    error_reg_in = 8'h00;
  end
  // Carrier sample toggles every cycle, so a stuck output shows at once
  always @(posedge aclk) carrier_in <= ~carrier_in;
  // One bit pulse per cycle, then the end strobe with the error byte
  task automatic send_stream(input int n, input logic [7:0] err);
    repeat (n) begin
      @(posedge aclk);
      rx_bit_valid <= 1'b1;
    end
    @(posedge aclk);
    rx_bit_valid <= 1'b0;
    rx_frame_end <= 1'b1;
    error_reg_in <= err;
    // Byte is only valid at the strobe; show its inverse afterwards
    @(posedge aclk);
    rx_frame_end <= 1'b0;
    error_reg_in <= ~err;
  endtask
endmodule // rxad_rf_model

//--- rxad_rx_ctrl.sv
// Receive sequencer: short frame filter, single/multi frame end, error byte append in multi mode
`include "rxad_cfg.svh"
module rxad_rx_ctrl (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  rxad_rx_if.rx      rx,
  input  wire logic  rx_bit_valid,
  input  wire logic  rx_frame_end,
  input  wire logic [7:0] error_reg_in
);
  rxad_pkg::rxad_rx_state_t state_r;   // Listening or idle
  logic [7:0]               cnt_r;     // Bits of current stream
  logic                     short_s;   // Stream too short
  logic                     drop_s;    // Short stream to be ignored

  // Short stream test; type B needs start of frame as well
  always_comb begin
    short_s = (cnt_r < `RXAD_SHORT_BITS);
    drop_s  = short_s && rx.ignore && ((rx.fmt != rxad_pkg::RXAD_FMT_B) || rx.sof_req);
  end

  // Receiver state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= rxad_pkg::RXAD_RX_IDLE;
    end else begin
      unique case (state_r)
        rxad_pkg::RXAD_RX_IDLE: begin
          if (rx.start) begin
            state_r <= rxad_pkg::RXAD_RX_LISTEN;
          end
        end
        rxad_pkg::RXAD_RX_LISTEN: begin
          if (rx.stop && !rx.start) begin
            state_r <= rxad_pkg::RXAD_RX_IDLE;
          end else if (rx_frame_end && !drop_s && !rx.multi) begin
            state_r <= rxad_pkg::RXAD_RX_IDLE;
          end
        end
      endcase
    end
  end

  // Bit counter, cleared at every stream end and when idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 8'h00;
    end else if (state_r == rxad_pkg::RXAD_RX_IDLE || rx_frame_end) begin
      cnt_r <= 8'h00;
    end else if (rx_bit_valid && cnt_r != 8'hff) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // Stream end pulses and error byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx.frame_done <= 1'b0;
      rx.discard    <= 1'b0;
      rx.push       <= 1'b0;
      rx.push_data  <= 8'h00;
      rx.last_count <= 8'h00;
    end else begin
      rx.frame_done <= 1'b0;
      rx.discard    <= 1'b0;
      rx.push       <= 1'b0;
      if (state_r == rxad_pkg::RXAD_RX_LISTEN && rx_frame_end && !rx.stop) begin
        rx.last_count <= cnt_r;
        rx.discard    <= drop_s;
        rx.frame_done <= !drop_s;
        if (!drop_s && rx.multi) begin
          rx.push      <= 1'b1;
          rx.push_data <= error_reg_in;
        end
      end
    end
  end

  assign rx.active = (state_r == rxad_pkg::RXAD_RX_LISTEN);
endmodule // rxad_rx_ctrl

//--- rxad_rx_if.sv
// Carrier between the register bank and the receive sequencer
interface rxad_rx_if;
  logic                 multi;      // Multi-frame receive
  logic                 ignore;     // Ignore short frames
  logic                 sof_req;    // Start of frame required
  rxad_pkg::rxad_fmt_t  fmt;        // Expected framing
  logic                 start;      // Arm receiver pulse
  logic                 stop;       // End reception pulse
  logic                 active;     // Receiver listening
  logic                 frame_done; // Valid frame pulse
  logic                 discard;    // Short frame dropped pulse
  logic                 push;       // Error byte push pulse
  logic [7:0]           push_data;  // Error byte
  logic [7:0]           last_count; // Bits of last stream
  modport ctrl (output multi, ignore, sof_req, fmt, start, stop,
                input active, frame_done, discard, push, push_data, last_count);
  modport rx   (input multi, ignore, sof_req, fmt, start, stop,
                output active, frame_done, discard, push, push_data, last_count);
endinterface

//--- rxad_top.sv
// Rx mode and antenna driver control block with AXI4-Lite register slave
`include "rxad_cfg.svh"
module rxad_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Analog and receive side
  input  wire logic        carrier_in,
  input  wire logic        tx_data_in,
  input  wire logic        ext_field_detected,
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_frame_end,
  input  wire logic [7:0]  error_reg_in,
  output logic             antenna_out_1,
  output logic             antenna_out_2,
  output logic             rx_active,
  output logic             rx_frame_done,
  output logic             rx_short_discard,
  output logic             fifo_push,
  output logic [7:0]       fifo_data,
  output logic [2:0]       rx_bit_rate,
  output logic             rx_crc_check_on,
  output logic [1:0]       rx_frame_format,
  output logic             rx_coding_active424
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [1:0] RESP_OKAY   = 2'h0;  // Mapped access
  localparam logic [1:0] RESP_SLVERR = 2'h2;  // Unmapped access

  rxad_rx_if           rxi ();                // Link to receive sequencer
  logic [7:0]          rx_mode_r;             // Receive mode register
  logic [7:0]          drv_ctl_r;             // Driver control, guard bit kept apart
  logic [7:0]          rx_aux_r;              // Start-of-frame requirement
  logic [3:0]          cmd_r;                 // Last command written
  logic                aw_hold_r;             // Write address captured
  logic [7:0]          awaddr_r;              // Captured write address
  logic                w_hold_r;              // Write data captured
  logic [31:0]         wdata_r;               // Captured write data
  logic [3:0]          wstrb_r;               // Captured strobes
  logic                bvalid_r;              // Write response pending
  logic [1:0]          bresp_r;               // Write response code
  logic                rvalid_r;              // Read data pending
  logic [31:0]         rdata_r;               // Read data
  logic [1:0]          rresp_r;               // Read response code
  logic                do_write;              // Both halves present
  logic                wr_lane0;              // Low byte strobed
  logic                wr_mode;               // Write hits rx mode
  logic                wr_ctl;                // Write hits driver control
  logic                wr_aux;                // Write hits aux register
  logic                wr_cmd;                // Write hits command
  logic                wr_hit;                // Write address mapped
  logic [7:0]          ctl_nxt;               // Driver control after write
  logic                guard_nxt;             // Guard after write
  logic [31:0]         rd_val;                // Read mux result
  logic                rd_hit;                // Read address mapped
  logic [1:0]          ant_r;                 // Antenna output flops
  logic [1:0]          ant_nxt;               // Antenna next values

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  ////////////////////////////////////////////////////////////////////////////
  // Each half is accepted once and held; a new write waits for the response
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign do_write      = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_lane0      = wstrb_r[0];

  // Address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_r <= 1'b0;
    end
  end

  // Data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wdata_r  <= 32'h00000000;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_r <= 1'b0;
    end
  end

  // Address decode of the held write; upper address bits must be zero too
  always_comb begin
    wr_mode = (awaddr_r[7:2] == `RXAD_ADDR_RX_MODE >> 2);
    wr_ctl  = (awaddr_r[7:2] == `RXAD_ADDR_DRV_CTL >> 2);
    wr_aux  = (awaddr_r[7:2] == `RXAD_ADDR_RX_AUX >> 2);
    wr_cmd  = (awaddr_r[7:2] == `RXAD_ADDR_CMD >> 2);
    wr_hit  = wr_mode || wr_ctl || wr_aux || wr_cmd ||
              (awaddr_r[7:2] == `RXAD_ADDR_STATUS >> 2);
  end

  // Write response; status is read-only but the write is answered OKAY
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////////////////////
  // Receive mode register; reserved rate codes are stored as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_mode_r <= `RXAD_RX_MODE_RST;
    end else if (do_write && wr_mode && wr_lane0) begin
      rx_mode_r <= wdata_r[7:0];
    end
  end

  // Aux register holding the start-of-frame requirement in bit 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_aux_r <= `RXAD_RX_AUX_RST;
    end else if (do_write && wr_aux && wr_lane0) begin
      rx_aux_r <= {7'h00, wdata_r[0]};
    end
  end

  // Driver control next value. The guard of this very write counts, so
  // one write can both arm the guard and be refused its enables.
  always_comb begin
    guard_nxt = wdata_r[`RXAD_DC_GUARD];
    ctl_nxt   = {wdata_r[7:3], 1'b0, wdata_r[1:0]};
    if (guard_nxt && ext_field_detected) begin
      ctl_nxt[1:0] = wdata_r[1:0] & drv_ctl_r[1:0];
    end
  end

  // Driver control register; the guard acts only within its own write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_ctl_r <= `RXAD_DRV_CTL_RST;
    end else if (do_write && wr_ctl && wr_lane0) begin
      drv_ctl_r <= ctl_nxt;
    end
  end

  // Command register; only the code is kept, its execution lives elsewhere
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= 4'h0;
    end else if (do_write && wr_cmd && wr_lane0) begin
      cmd_r <= wdata_r[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive sequencer hookup
  ////////////////////////////////////////////////////////////////////////////
  assign rxi.multi   = rx_mode_r[`RXAD_RM_MULTI];
  assign rxi.ignore  = rx_mode_r[`RXAD_RM_IGNORE];
  assign rxi.sof_req = rx_aux_r[0];
  assign rxi.fmt     = rxad_pkg::rxad_fmt_t'(rx_mode_r[`RXAD_RM_FMT_HI:0]);

  // Receive and transceive both arm the receiver
  assign rxi.start = do_write && wr_cmd && wr_lane0 &&
                     (wdata_r[3:0] == `RXAD_CMD_RECEIVE ||
                      wdata_r[3:0] == `RXAD_CMD_TRANSCEIVE);

  // other command or cleared multi bit
  assign rxi.stop = (do_write && wr_cmd && wr_lane0 &&
                     wdata_r[3:0] != `RXAD_CMD_RECEIVE) ||
                    (do_write && wr_mode && wr_lane0 &&
                     rx_mode_r[`RXAD_RM_MULTI] && !wdata_r[`RXAD_RM_MULTI]);

  rxad_rx_ctrl u_rx (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .rx           (rxi),
    .rx_bit_valid (rx_bit_valid),
    .rx_frame_end (rx_frame_end),
    .error_reg_in (error_reg_in)
  );

  assign rx_active        = rxi.active;
  assign rx_frame_done    = rxi.frame_done;
  assign rx_short_discard = rxi.discard;
  assign fifo_push        = rxi.push;
  assign fifo_data        = rxi.push_data;

  ////////////////////////////////////////////////////////////////////////////
  // Receive configuration outputs
  ////////////////////////////////////////////////////////////////////////////
  // rate to decoder
  assign rx_bit_rate     = rx_mode_r[`RXAD_RM_RATE_HI:`RXAD_RM_RATE_LO];
  assign rx_crc_check_on = rx_mode_r[`RXAD_RM_CRC];
  assign rx_frame_format = rx_mode_r[`RXAD_RM_FMT_HI:0];

  assign rx_coding_active424 = (rx_bit_rate > `RXAD_RATE_424) &&
                               (rx_bit_rate <= `RXAD_RATE_3392);

  ////////////////////////////////////////////////////////////////////////////
  // Antenna drivers
  ////////////////////////////////////////////////////////////////////////////
  // Enabled output carries the carrier gated by transmit data, or the plain carrier on driver 2 with CW set; disabled
  // output rests low. Inversion applies after gating, so an inverted
  // disabled driver rests high. Outputs are registered, which adds one
  // cycle but keeps glitches off the pins.
  for (genvar d = 0; d < 2; d++) begin : g_drv
    logic en_s;     // Driver enabled
    logic cw_s;     // Unmodulated carrier wanted
    logic wave_s;   // Output before inversion
    always_comb begin
      en_s = drv_ctl_r[d];
      cw_s = (d == 1) && drv_ctl_r[`RXAD_DC_CW];
      if (en_s) begin
        wave_s = carrier_in && (cw_s || tx_data_in);
        ant_nxt[d] = wave_s ^ drv_ctl_r[`RXAD_DC_INV_ON + d];
      end else begin
        wave_s = 1'b0;
        ant_nxt[d] = wave_s ^ drv_ctl_r[`RXAD_DC_INV_OFF + d];
      end
    end
  end

  // Antenna output flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ant_r <= 2'h0;
    end else begin
      ant_r <= ant_nxt;
    end
  end

  assign antenna_out_1 = ant_r[0];
  assign antenna_out_2 = ant_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  ////////////////////////////////////////////////////////////////////////////
  // Read mux; the guard bit is write-only and reads as zero
  always_comb begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr[7:2])
      `RXAD_ADDR_CMD >> 2:     rd_val = {28'h0000000, cmd_r};
      `RXAD_ADDR_RX_MODE >> 2: rd_val = {24'h000000, rx_mode_r};
      `RXAD_ADDR_DRV_CTL >> 2: rd_val = {24'h000000, drv_ctl_r};
      `RXAD_ADDR_RX_AUX >> 2:  rd_val = {24'h000000, rx_aux_r};
      `RXAD_ADDR_STATUS >> 2:  rd_val = {16'h0000, rxi.last_count, 7'h00, rxi.active};
      default:                 rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_r;

  // Read data is captured with the address, one cycle of latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

endmodule // rxad_top

//--- rxad_top_checker.sv
// Port-level assertions for the rx mode and antenna driver block
module rxad_top_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        rx_active,
  input wire logic        rx_frame_done,
  input wire logic        rx_short_discard,
  input wire logic        fifo_push,
  input wire logic [7:0]  fifo_data,
  input wire logic [7:0]  error_reg_in,
  input wire logic [2:0]  rx_bit_rate,
  input wire logic        rx_coding_active424
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_rate424; rx_coding_active424 == (rx_bit_rate inside {3'h3, 3'h4, 3'h5}); endproperty
  a_rate424: assert property (p_rate424) else $error("fast rate coding wrong");
  property p_short; rx_short_discard |-> rx_active && !fifo_push && !rx_frame_done; endproperty
  a_short: assert property (p_short) else $error("short stream not ignored");
  property p_done_cause; rx_frame_done |-> $past(rx_active); endproperty
  a_done_cause: assert property (p_done_cause) else $error("frame end while idle");
  property p_single; rx_frame_done && !fifo_push |-> !rx_active; endproperty
  a_single: assert property (p_single) else $error("receiver left on after frame");
  property p_multi; fifo_push |-> rx_frame_done && rx_active; endproperty
  a_multi: assert property (p_multi) else $error("multi receive ended itself");
  property p_err_byte; fifo_push |-> fifo_data == $past(error_reg_in); endproperty
  a_err_byte: assert property (p_err_byte) else $error("error byte wrong");
  // Main scenarios reached
  c_push: cover property (fifo_push);
  c_discard: cover property (rx_short_discard);
  c_done: cover property (rx_frame_done && !rx_active);
endmodule // rxad_top_checker

//--- test_rx_mode_and_antenna_driver_ctrl.sv
// Self-checking bench for the rx mode and antenna driver block
`include "rxad_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module test_rx_mode_and_antenna_driver_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, tx_data_in = 1'b0, ext_field_detected = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, carrier_in, rx_bit_valid;
  logic rx_frame_end, antenna_out_1, antenna_out_2, rx_active, rx_frame_done, rx_short_discard, fifo_push;
  logic rx_crc_check_on, rx_coding_active424, car_q, mod_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, rx_frame_format, rsp;
  logic [2:0] rx_bit_rate;
  logic [7:0] error_reg_in, fifo_data;
  logic [31:0] s_axi_rdata, rd;
  int failures = 0, n_compared = 0;
  always #25 aclk = ~aclk;
  rxad_top DUT (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .carrier_in, .tx_data_in, .ext_field_detected, .rx_bit_valid, .rx_frame_end,
    .error_reg_in, .antenna_out_1, .antenna_out_2, .rx_active, .rx_frame_done, .rx_short_discard, .fifo_push,
    .fifo_data, .rx_bit_rate, .rx_crc_check_on, .rx_frame_format, .rx_coding_active424);
  rxad_rf_model u_rf (.aclk, .carrier_in, .rx_bit_valid, .rx_frame_end, .error_reg_in);
  // Inputs as the outputs saw them, one register stage late
  always @(posedge aclk) begin
    car_q <= carrier_in;
    mod_q <= carrier_in & tx_data_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // A bound that ran out is a failure and ends the run
  task automatic tmo(input int k);
    if (k >= 50) begin
      failures++;
      $display("mismatch at %0t: no answer", $time);
      stop_test();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(k);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    int k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 50);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(k);
  endtask
  // Stream of n bits; e holds done, discard, push and listening at the pulse
  task automatic stream(input int n, input logic [7:0] err, input logic [3:0] e);
    int k = 0;
    u_rf.send_stream(n, err);
    do begin
      @(posedge aclk);
      k++;
    end while (!(rx_frame_done || rx_short_discard) && k < 50);
    tmo(k);
    `CHK({rx_frame_done, rx_short_discard, fifo_push, rx_active}, e)
    if (fifo_push) `CHK(fifo_data, err)
  endtask
  task automatic arm(input logic [7:0] mode, input logic [7:0] aux);
    axw(`RXAD_ADDR_RX_MODE, mode, rsp);
    axw(`RXAD_ADDR_RX_AUX, aux, rsp);
    axw(`RXAD_ADDR_CMD, 8'h08, rsp);
    repeat (2) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    axr(`RXAD_ADDR_DRV_CTL, rd);
    `CHK(rd, 32'h80)
    `CHK({antenna_out_2, antenna_out_1}, 2'h0)
  endtask
  // Every inversion, enable and carrier setting against the carrier model
  task automatic t_ant();
    logic [7:0] cfg [6] = '{8'h80, 8'h03, 8'hc3, 8'h30, 8'h0b, 8'h41};
    foreach (cfg[i]) begin
      axw(`RXAD_ADDR_DRV_CTL, cfg[i], rsp);
      repeat (4) begin
        @(posedge aclk);
        tx_data_in <= tx_data_in ^ carrier_in;
        @(negedge aclk);
        `CHK(antenna_out_1, cfg[i][0] ? mod_q ^ cfg[i][6] : cfg[i][4])
        `CHK(antenna_out_2, cfg[i][1] ? (cfg[i][3] ? car_q : mod_q) ^ cfg[i][7] : cfg[i][5])
      end
    end
  endtask
  // Guard refuses enables under a field; also an unmapped place
  task automatic t_guard();
    logic [7:0] wr [5] = '{8'h00, 8'h07, 8'h03, 8'h04, 8'h07};
    logic [7:0] ex [5] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h03};
    foreach (wr[i]) begin
      ext_field_detected <= (i < 4);
      axw(`RXAD_ADDR_DRV_CTL, wr[i], rsp);
      axr(`RXAD_ADDR_DRV_CTL, rd);
      `CHK(rd, {24'h0, ex[i]})
    end
    axw(8'h40, 8'hff, rsp);
    `CHK(rsp, 2'h2)
    axr(8'h40, rd);
    `CHK(rd, 32'h0)
    `CHK(rsp, 2'h2)
  endtask
  task automatic t_rx();
    arm(8'h00, 8'h00);
    stream(5, 8'h11, 4'b1000);
    arm(8'h08, 8'h00);
    stream(3, 8'h22, 4'b0101);
    stream(4, 8'h33, 4'b1000);
    arm(8'h0b, 8'h00);
    stream(3, 8'h44, 4'b1000);
    arm(8'h0b, 8'h01);
    stream(3, 8'h55, 4'b0101);
  endtask
  task automatic t_multi();
    arm(8'h04, 8'h00);
    stream(4, 8'h5a, 4'b1011);
    axw(`RXAD_ADDR_CMD, 8'h0c, rsp);
    stream(6, 8'ha5, 4'b1011);
    axw(`RXAD_ADDR_RX_MODE, 8'h00, rsp);
    repeat (2) @(posedge aclk);
    `CHK(rx_active, 1'b0)
    arm(8'h04, 8'h00);
    axw(`RXAD_ADDR_CMD, 8'h00, rsp);
    repeat (2) @(posedge aclk);
    `CHK(rx_active, 1'b0)
  endtask
  task automatic t_rates();
    for (int r = 0; r < 6; r++) begin
      for (int f = 0; f < 4; f++) begin
        axw(`RXAD_ADDR_RX_MODE, {r != 0, r[2:0], 2'h0, f[1:0]}, rsp);
        @(posedge aclk);
        `CHK({rx_crc_check_on, rx_bit_rate}, {r != 0, r[2:0]})
        `CHK(rx_frame_format, f[1:0])
        `CHK(rx_coding_active424, r > 2)
      end
    end
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_ant();
    t_guard();
    t_rx();
    t_multi();
    t_rates();
    stop_test();
  end
endmodule // test_rx_mode_and_antenna_driver_ctrl
bind rxad_top rxad_top_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .rx_active(rx_active), .rx_frame_done(rx_frame_done),
  .rx_short_discard(rx_short_discard), .fifo_push(fifo_push), .fifo_data(fifo_data),
  .error_reg_in(error_reg_in), .rx_bit_rate(rx_bit_rate), .rx_coding_active424(rx_coding_active424));
